// ==== pkg/tscr_defines.vh ====
`ifndef TSCR_DEFINES_VH
`define TSCR_DEFINES_VH

// register indices, one 16-bit word each
`define TSCR_IDX_INFO      8'h10
`define TSCR_IDX_GEST      8'h11
`define TSCR_IDX_TOUCH0    8'h12
`define TSCR_IDX_TOUCH1    8'h13
`define TSCR_IDX_TOUCH2    8'h14
`define TSCR_IDX_TUNE      8'h15
`define TSCR_IDX_CTRL      8'h16
`define TSCR_IDX_CFG       8'h17

// info word fields
`define TSCR_INFO_LP_DET   14
`define TSCR_INFO_OVF      12
`define TSCR_INFO_MOTION   10
`define TSCR_INFO_CNT_HI   9
`define TSCR_INFO_CNT_LO   8
`define TSCR_INFO_RST      7
`define TSCR_INFO_LP_RCL   6
`define TSCR_INFO_LP_ERR   5
`define TSCR_INFO_PD_RCL   4
`define TSCR_INFO_PD_ERR   3

// control word fields
`define TSCR_CTRL_SRST     9
`define TSCR_CTRL_ACK      7
`define TSCR_CTRL_LP_RCL   6
`define TSCR_CTRL_PD_RCL   5
`define TSCR_CTRL_LP_SEED  4
`define TSCR_CTRL_PD_SEED  3

// config word fields
`define TSCR_CFG_EVT_HI    14
`define TSCR_CFG_EVT_MODE  8
`define TSCR_CFG_MANUAL    7

// calibration word fields
`define TSCR_TUNE_FDIV_LO  9
`define TSCR_TUNE_CMUL_LO  5

// reset values and write masks
`define TSCR_TUNE_RST      16'h0221
`define TSCR_CFG_RST       16'h0000
`define TSCR_MODE_ACTIVE   3'h0
`define TSCR_CFG_MASK      16'h6F80
`define TSCR_TUNE_MASK     16'h3FFF

`endif

// ==== design/tscr_regs.v ====
`timescale 1ns/100ps
`include "tscr_defines.vh"
module tscr_regs #(
  parameter [6:0] DEV_ADDR = 7'h56
) (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  output reg         rdy_n_o,
  input  wire        cycle_done_i,
  input  wire        autoprox_i,
  input  wire [4:0]  event_i,
  input  wire        lp_detect_i,
  input  wire        finger_overflow_i,
  input  wire        pad_motion_i,
  input  wire [1:0]  finger_count_i,
  input  wire        lp_recal_done_i,
  input  wire        lp_tune_error_i,
  input  wire        pad_recal_done_i,
  input  wire        pad_tune_error_i,
  input  wire [2:0]  auto_mode_i,
  input  wire [5:0]  gesture_i,
  input  wire [29:0] touch_i,
  input  wire        lp_sensed_i,
  input  wire        pad_sensed_i,
  output reg  [2:0]  current_power_mode_o,
  output reg         manual_mode_o,
  output reg         lp_recal_o,
  output reg         pad_recal_o,
  output reg         lp_reseed_o,
  output reg         pad_reseed_o,
  output reg         soft_reset_o,
  output reg  [4:0]  fine_div_o,
  output reg  [3:0]  coarse_mult_o,
  output reg  [4:0]  coarse_div_o
);

  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_REG  = 9'h004;
  localparam [8:0] S_WR   = 9'h008;
  localparam [8:0] S_ACK  = 9'h010;
  localparam [8:0] S_RD   = 9'h020;
  localparam [8:0] S_RACK = 9'h040;
  localparam [8:0] S_RLD  = 9'h080;
  localparam [8:0] S_SKIP = 9'h100;
  //////////////////////////////////////////////////////////////////////
  // reset: external plus self-reset after a window closes
  reg         srst_r;
  wire        rst = ~reset_n_i | srst_r;
  //////////////////////////////////////////////////////////////////////
  // pin edges; pins are taken as synchronous to clk_i
  reg         scl_q_r;
  reg         sda_q_r;
  wire        scl_rise = scl_i & ~scl_q_r;
  wire        scl_fall = ~scl_i & scl_q_r;
  wire        start_c  = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire        stop_c   = scl_i & scl_q_r & ~sda_q_r & sda_i;
  always @(posedge clk_i) begin
    if (~reset_n_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // register storage
  reg  [15:0] info_r;
  reg  [15:0] gest_r;
  reg  [29:0] touch_r;
  reg  [15:0] tune_r;
  reg  [15:0] cfg_r;
  reg  [2:0]  mode_sel_r;
  reg         show_rst_r;
  reg         srst_pend_r;
  reg         lp_q_r;
  reg         pad_q_r;
  reg         win_r;
  reg         wr_stb_r;
  reg  [7:0]  wr_idx_r;
  reg  [15:0] wr_dat_r;
  wire        manual = cfg_r[`TSCR_CFG_MANUAL];
  wire [2:0]  mode_now = manual ? mode_sel_r : auto_mode_i;
  wire        ctrl_wr = wr_stb_r & (wr_idx_r == `TSCR_IDX_CTRL);
  // status words follow the sensing engine every cycle
  always @(posedge clk_i) begin
    if (rst) begin
      info_r  <= 16'h0000;
      gest_r  <= 16'h0000;
      touch_r <= 30'h00000000;
    end else begin
      info_r                    <= 16'h0000;
      info_r[`TSCR_INFO_LP_DET] <= lp_detect_i;
      info_r[`TSCR_INFO_OVF]    <= finger_overflow_i;
      info_r[`TSCR_INFO_MOTION] <= pad_motion_i;
      info_r[`TSCR_INFO_CNT_HI:`TSCR_INFO_CNT_LO] <= (finger_count_i == 2'h3) ?
                                   2'h2 : finger_count_i;
      info_r[`TSCR_INFO_LP_RCL] <= lp_recal_done_i;
      info_r[`TSCR_INFO_LP_ERR] <= lp_tune_error_i;
      info_r[`TSCR_INFO_PD_RCL] <= pad_recal_done_i;
      info_r[`TSCR_INFO_PD_ERR] <= pad_tune_error_i;
      info_r[2:0]               <= mode_now;
      gest_r                    <= {10'h000, gesture_i};
      touch_r                   <= touch_i;
    end
  end
  // reset flag: only a reset sets it, so no set/clear race exists
  always @(posedge clk_i) begin
    if (rst) begin
      show_rst_r <= 1'b1;
    end else if (ctrl_wr & wr_dat_r[`TSCR_CTRL_ACK]) begin
      show_rst_r <= 1'b0;
    end
  end
  // host-written words
  always @(posedge clk_i) begin
    if (rst) begin
      tune_r     <= `TSCR_TUNE_RST;
      cfg_r      <= `TSCR_CFG_RST;
      mode_sel_r <= `TSCR_MODE_ACTIVE;
    end else if (wr_stb_r) begin
      if (wr_idx_r == `TSCR_IDX_TUNE) begin
        tune_r <= wr_dat_r & `TSCR_TUNE_MASK;
      end
      if (wr_idx_r == `TSCR_IDX_CFG) begin
        cfg_r <= wr_dat_r & `TSCR_CFG_MASK;
      end
      if (ctrl_wr) begin
        mode_sel_r <= wr_dat_r[2:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // queued recalibration: held until that channel is next sensed
  always @(posedge clk_i) begin
    if (rst) begin
      lp_q_r       <= 1'b0;
      pad_q_r      <= 1'b0;
      lp_recal_o   <= 1'b0;
      pad_recal_o  <= 1'b0;
      lp_reseed_o  <= 1'b0;
      pad_reseed_o <= 1'b0;
    end else begin
      // a new request in the sensing cycle is kept, not lost
      lp_q_r       <= (lp_q_r & ~lp_sensed_i) |
                      (ctrl_wr & wr_dat_r[`TSCR_CTRL_LP_RCL]);
      pad_q_r      <= (pad_q_r & ~pad_sensed_i) |
                      (ctrl_wr & wr_dat_r[`TSCR_CTRL_PD_RCL]);
      lp_recal_o   <= lp_q_r & lp_sensed_i;
      pad_recal_o  <= pad_q_r & pad_sensed_i;
      lp_reseed_o  <= ctrl_wr & wr_dat_r[`TSCR_CTRL_LP_SEED];
      pad_reseed_o <= ctrl_wr & wr_dat_r[`TSCR_CTRL_PD_SEED];
    end
  end
  //////////////////////////////////////////////////////////////////////
  // self-reset waits for the stop that ends the window
  always @(posedge clk_i) begin
    if (~reset_n_i) begin
      srst_r <= 1'b0;
    end else begin
      srst_r <= srst_pend_r & stop_c;
    end
  end
  always @(posedge clk_i) begin
    if (rst) begin
      srst_pend_r <= 1'b0;
    end else if (ctrl_wr & wr_dat_r[`TSCR_CTRL_SRST]) begin
      srst_pend_r <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // communication window, ready low while open
  wire evt_hit = |(event_i & {cfg_r[14:13], cfg_r[11:9]});
  always @(posedge clk_i) begin
    if (rst) begin
      win_r <= 1'b0;
    end else if (stop_c) begin
      win_r <= 1'b0;
    end else if (cycle_done_i) begin
      if (cfg_r[`TSCR_CFG_EVT_MODE]) begin
        win_r <= win_r | evt_hit;
      end else begin
        win_r <= win_r | ~autoprox_i;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  always @(posedge clk_i) begin
    if (rst) begin
      rdy_n_o              <= 1'b1;
      current_power_mode_o <= `TSCR_MODE_ACTIVE;
      manual_mode_o        <= 1'b0;
      soft_reset_o         <= 1'b0;
      fine_div_o           <= 5'h00;
      coarse_mult_o        <= 4'h0;
      coarse_div_o         <= 5'h00;
    end else begin
      rdy_n_o              <= ~win_r;
      current_power_mode_o <= mode_now;
      manual_mode_o        <= manual;
      soft_reset_o         <= srst_pend_r & stop_c;
      fine_div_o           <= tune_r[13:9];
      coarse_mult_o        <= tune_r[8:5];
      coarse_div_o         <= tune_r[4:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux; unmapped indices and unused bits read zero
  reg  [7:0]  ptr_r;
  reg  [15:0] rd_word;

  always @* begin
    case (ptr_r)
      `TSCR_IDX_INFO:   rd_word = {info_r[15:8], show_rst_r, info_r[6:0]};
      `TSCR_IDX_GEST:   rd_word = gest_r;
      `TSCR_IDX_TOUCH0: rd_word = touch_r[15:0];
      `TSCR_IDX_TOUCH1: rd_word = {2'h0, touch_r[29:16]};
      `TSCR_IDX_TOUCH2: rd_word = 16'h0000;
      `TSCR_IDX_TUNE:   rd_word = tune_r;
      `TSCR_IDX_CTRL:   rd_word = {13'h0000, mode_sel_r};
      `TSCR_IDX_CFG:    rd_word = cfg_r;
      default:          rd_word = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // two-wire slave: reg index byte, then words low byte first
  reg  [8:0]  st_r;
  reg  [2:0]  cnt_r;
  reg         full_r;
  reg  [7:0]  sh_r;
  reg  [7:0]  tx_r;
  reg  [7:0]  lo_r;
  reg         hi_r;
  reg         rw_r;
  reg  [1:0]  ph_r;

  always @(posedge clk_i) begin
    if (rst) begin
      st_r     <= S_IDLE;
      cnt_r    <= 3'h0;
      full_r   <= 1'b0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      lo_r     <= 8'h00;
      hi_r     <= 1'b0;
      rw_r     <= 1'b0;
      ph_r     <= 2'h0;
      ptr_r    <= 8'h00;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_idx_r <= 8'h00;
      wr_dat_r <= 16'h0000;
    end else begin
      wr_stb_r <= 1'b0;
      sda_o    <= 1'b0;
      if (stop_c) begin
        st_r     <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_c) begin
        st_r     <= S_ADDR;
        cnt_r    <= 3'h0;
        full_r   <= 1'b0;
        hi_r     <= 1'b0;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_r)
          S_IDLE, S_SKIP: begin
            sda_oe_o <= 1'b0;
          end
          S_ADDR, S_REG, S_WR: begin
            if (scl_rise) begin
              sh_r   <= {sh_r[6:0], sda_i};
              cnt_r  <= cnt_r + 3'h1;
              full_r <= (cnt_r == 3'h7);
            end else if (scl_fall & full_r) begin
              full_r   <= 1'b0;
              sda_oe_o <= 1'b1;
              st_r     <= S_ACK;
              if (st_r == S_ADDR) begin
                rw_r <= sh_r[0];
                ph_r <= 2'h0;
                if (sh_r[7:1] != DEV_ADDR) begin
                  sda_oe_o <= 1'b0;
                  st_r     <= S_SKIP;
                end
              end else if (st_r == S_REG) begin
                ptr_r <= sh_r;
                hi_r  <= 1'b0;
                ph_r  <= 2'h1;
              end else begin
                ph_r <= 2'h2;
                hi_r <= ~hi_r;
                if (~hi_r) begin
                  lo_r <= sh_r;
                end else begin
                  wr_stb_r <= 1'b1;
                  wr_idx_r <= ptr_r;
                  wr_dat_r <= {sh_r, lo_r};
                  ptr_r    <= ptr_r + 8'h01;
                end
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              if ((ph_r == 2'h0) & rw_r) begin
                st_r <= S_RLD;
              end else if (ph_r == 2'h0) begin
                st_r <= S_REG;
              end else begin
                st_r <= S_WR;
              end
            end
          end
          S_RLD: begin
            // byte taken at load so a word cannot tear mid-byte
            tx_r     <= hi_r ? rd_word[15:8] : rd_word[7:0];
            sda_oe_o <= hi_r ? ~rd_word[15] : ~rd_word[7];
            hi_r     <= ~hi_r;
            if (hi_r) begin
              ptr_r <= ptr_r + 8'h01;
            end
            cnt_r <= 3'h0;
            st_r  <= S_RD;
          end
          S_RD: begin
            if (scl_fall) begin
              cnt_r <= cnt_r + 3'h1;
              if (cnt_r == 3'h7) begin
                sda_oe_o <= 1'b0;
                st_r     <= S_RACK;
              end else begin
                tx_r     <= {tx_r[6:0], 1'b0};
                sda_oe_o <= ~tx_r[6];
              end
            end
          end
          S_RACK: begin
            sda_oe_o <= 1'b0;
            if (scl_rise) begin
              full_r <= ~sda_i;
              if (sda_i) begin
                st_r <= S_SKIP;
              end
            end else if (scl_fall & full_r) begin
              full_r <= 1'b0;
              st_r   <= S_RLD;
            end
          end
          default: begin
            st_r     <= S_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // tscr_regs

// ==== sim/tscr_props.sv ====
`timescale 1ns/100ps
module tscr_props (
  input wire       clk_i,
  input wire       reset_n_i,
  input wire       scl_i,
  input wire       sda_oe_o,
  input wire       rdy_n_o,
  input wire       cycle_done_i,
  input wire       lp_sensed_i,
  input wire       pad_sensed_i,
  input wire [2:0] auto_mode_i,
  input wire [2:0] current_power_mode_o,
  input wire       manual_mode_o,
  input wire       lp_recal_o,
  input wire       pad_recal_o,
  input wire       lp_reseed_o,
  input wire       pad_reseed_o,
  input wire       soft_reset_o,
  input wire [4:0] fine_div_o,
  input wire [3:0] coarse_mult_o,
  input wire [4:0] coarse_div_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // edges since any reset; outputs settle to reset values a few edges late
  reg [1:0] quiet_r;
  always @(posedge clk_i) begin
    if (!reset_n_i || soft_reset_o) quiet_r <= 2'h0;
    else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_recal_lowpower: assert property (lp_recal_o |-> $past(lp_sensed_i) ##1 !lp_recal_o)
    else $error("low-power recal without sensing");
  a_recal_pad: assert property (pad_recal_o |-> $past(pad_sensed_i) ##1 !pad_recal_o)
    else $error("pad recal without sensing");
  a_reseed_lowpower: assert property (lp_reseed_o |-> $past(sda_oe_o) ##1 !lp_reseed_o)
    else $error("low-power reseed without write");
  a_reseed_pad: assert property (pad_reseed_o |-> $past(sda_oe_o) ##1 !pad_reseed_o)
    else $error("pad reseed without write");
  a_soft_reset_stop: assert property (soft_reset_o |-> scl_i && $past(scl_i) && !sda_oe_o ##1 !soft_reset_o)
    else $error("soft reset outside bus stop");
  a_window_cause: assert property ($fell(rdy_n_o) |-> $past(cycle_done_i, 2))
    else $error("window opened without cycle end");
  a_mode_auto: assert property (quiet_r == 2'h3 && !manual_mode_o && !$past(manual_mode_o)
    |-> current_power_mode_o == $past(auto_mode_i))
    else $error("auto mode not followed");
  a_mode_held: assert property (manual_mode_o && $past(manual_mode_o) && $changed(current_power_mode_o)
    |-> $past(sda_oe_o))
    else $error("manual mode changed without write");
  a_tune_write: assert property (quiet_r == 2'h3 && $changed({fine_div_o, coarse_mult_o, coarse_div_o})
    |-> $past(sda_oe_o))
    else $error("calibration changed without write");
endmodule // tscr_props

bind tscr_regs tscr_props u_props (.clk_i, .reset_n_i, .scl_i, .sda_oe_o, .rdy_n_o, .cycle_done_i, .lp_sensed_i,
  .pad_sensed_i, .auto_mode_i, .current_power_mode_o, .manual_mode_o, .lp_recal_o, .pad_recal_o, .lp_reseed_o,
  .pad_reseed_o, .soft_reset_o, .fine_div_o, .coarse_mult_o, .coarse_div_o);

// ==== sim/tscr_host.sv ====
`timescale 1ns/100ps
// host on the two-wire bus; the data line has a pull-up, so a released
// line reads one unless the device pulls it low
module tscr_host #(
  parameter [6:0] ADDR = 7'h56
) (
  input  wire clk_i,
  input  wire sda_oe_i,
  output reg  scl_o,
  output wire sda_o
);
  reg drv_r = 1'b1;
  assign sda_o = drv_r & ~sda_oe_i;
  initial scl_o = 1'b1;
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  // four clocks high and six low per bit, above the three-clock minimum
  task bitx(input b, output r);
    begin
      drv_r = b;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      r = sda_o;
      scl_o = 1'b0;
      tick(2);
    end
  endtask
  task start;
    begin
      drv_r = 1'b1;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      drv_r = 1'b0;
      tick(4);
      scl_o = 1'b0;
      tick(2);
    end
  endtask
  task stop;
    begin
      drv_r = 1'b0;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      drv_r = 1'b1;
      tick(4);
    end
  endtask
  task xfer(input [7:0] b, input ak, output [7:0] r);
    integer i;
    reg     x;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitx(b[i], x);
        r[i] = x;
      end
      bitx(ak, x);
    end
  endtask
  // words go low byte first
  task wr(input [7:0] idx, input [15:0] d);
    reg [7:0] r;
    begin
      start;
      xfer({ADDR, 1'b0}, 1'b1, r);
      xfer(idx, 1'b1, r);
      xfer(d[7:0], 1'b1, r);
      xfer(d[15:8], 1'b1, r);
      stop;
    end
  endtask
  task rd(input [7:0] idx, output [15:0] d);
    reg [7:0] r;
    begin
      start;
      xfer({ADDR, 1'b0}, 1'b1, r);
      xfer(idx, 1'b1, r);
      start;
      xfer({ADDR, 1'b1}, 1'b1, r);
      xfer(8'hFF, 1'b0, d[7:0]);
      xfer(8'hFF, 1'b1, d[15:8]);
      stop;
    end
  endtask
endmodule // tscr_host

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`include "tscr_defines.vh"
module testbench;
  reg         clk_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg         cycle_done_i = 1'b0;
  reg         autoprox_i = 1'b0;
  reg  [4:0]  event_i = 5'h00;
  reg         lp_detect_i, finger_overflow_i, pad_motion_i, lp_recal_done_i;
  reg         lp_tune_error_i, pad_recal_done_i, pad_tune_error_i;
  reg  [1:0]  finger_count_i;
  reg  [2:0]  auto_mode_i;
  reg  [5:0]  gesture_i = 6'h00;
  reg  [29:0] touch_i = 30'h0;
  reg         lp_sensed_i = 1'b0;
  reg         pad_sensed_i = 1'b0;
  wire        scl_i, sda_i, sda_o, sda_oe_o, rdy_n_o, manual_mode_o;
  wire        lp_recal_o, pad_recal_o, lp_reseed_o, pad_reseed_o, soft_reset_o;
  wire [2:0]  current_power_mode_o;
  wire [4:0]  fine_div_o, coarse_div_o;
  wire [3:0]  coarse_mult_o;
  integer     fails = 0;
  integer     num_checks = 0;
  integer     n_lrc = 0, n_prc = 0, n_lrs = 0, n_prs = 0, n_srst = 0;
  integer     m;
  reg  [15:0] v;
  always #4 clk_i = ~clk_i;
  tscr_regs dut (.clk_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .rdy_n_o, .cycle_done_i, .autoprox_i,
    .event_i, .lp_detect_i, .finger_overflow_i, .pad_motion_i, .finger_count_i, .lp_recal_done_i, .lp_tune_error_i,
    .pad_recal_done_i, .pad_tune_error_i, .auto_mode_i, .gesture_i, .touch_i, .lp_sensed_i, .pad_sensed_i,
    .current_power_mode_o, .manual_mode_o, .lp_recal_o, .pad_recal_o, .lp_reseed_o, .pad_reseed_o,
    .soft_reset_o, .fine_div_o, .coarse_mult_o, .coarse_div_o);
  tscr_host host (.clk_i, .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
  // pulse counters, so a one-shot that repeats shows up as a wrong count
  // counting waits for reset, outputs are unknown before the first edge
  always @(posedge clk_i) begin
    if (reset_n_i) begin
      n_lrc <= n_lrc + lp_recal_o;
      n_prc <= n_prc + pad_recal_o;
      n_lrs <= n_lrs + lp_reseed_o;
      n_prs <= n_prs + pad_reseed_o;
      n_srst <= n_srst + soft_reset_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input [7:0] idx, input [15:0] e);
    begin
      host.rd(idx, v);
      chk(v, e);
    end
  endtask
  task stat(input [11:0] s);
    begin
      {lp_detect_i, finger_overflow_i, pad_motion_i, finger_count_i, lp_recal_done_i, lp_tune_error_i,
        pad_recal_done_i, pad_tune_error_i, auto_mode_i} = s;
    end
  endtask
  task sense;
    begin
      lp_sensed_i = 1'b1;
      pad_sensed_i = 1'b1;
      cyc(1);
      lp_sensed_i = 1'b0;
      pad_sensed_i = 1'b0;
      cyc(3);
    end
  endtask
  task win(input a, input [4:0] e, input x);
    begin
      autoprox_i = a;
      event_i = e;
      cycle_done_i = 1'b1;
      cyc(1);
      cycle_done_i = 1'b0;
      event_i = 5'h00;
      autoprox_i = 1'b0;
      cyc(2);
      chk(rdy_n_o, !x);
      if (x) begin
        host.rd(`TSCR_IDX_INFO, v);
        cyc(3);
        chk(rdy_n_o, 1'b1);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    stat(12'hBB4);
    cyc(10);
    reset_n_i = 1'b1;
    cyc(2);
    rdchk(`TSCR_IDX_TUNE, 16'h0221);
    chk({fine_div_o, coarse_mult_o, coarse_div_o}, 16'h0221);
    rdchk(`TSCR_IDX_INFO, 16'h46B4);
    stat(12'h4C9);
    rdchk(`TSCR_IDX_INFO, 16'h11C9);
    gesture_i = 6'h2A;
    rdchk(`TSCR_IDX_GEST, 16'h002A);
    gesture_i = 6'h15;
    host.wr(`TSCR_IDX_GEST, 16'hFFFF);
    rdchk(`TSCR_IDX_GEST, 16'h0015);
    touch_i = 30'h2ABC1234;
    rdchk(`TSCR_IDX_TOUCH0, 16'h1234);
    rdchk(`TSCR_IDX_TOUCH1, 16'h2ABC);
    rdchk(`TSCR_IDX_TOUCH2, 16'h0000);
    rdchk(8'h30, 16'h0000);
    chk(sda_o, 1'b0);
    for (m = 0; m < 2; m = m + 1) begin
      v = m ? 16'h1A4B : 16'hFFFF;
      host.wr(`TSCR_IDX_TUNE, v);
      chk({fine_div_o, coarse_mult_o, coarse_div_o}, v[13:0]);
      rdchk(`TSCR_IDX_TUNE, v & 16'h3FFF);
    end
    host.wr(`TSCR_IDX_CTRL, 16'h0080);
    rdchk(`TSCR_IDX_INFO, 16'h1149);
    host.wr(`TSCR_IDX_CTRL, 16'h0000);
    rdchk(`TSCR_IDX_INFO, 16'h1149);
    host.wr(`TSCR_IDX_CTRL, 16'h0078);
    cyc(4);
    chk(n_lrs, 1);
    chk(n_prs, 1);
    chk(n_lrc + n_prc, 0);
    sense;
    chk(n_lrc, 1);
    chk(n_prc, 1);
    sense;
    chk(n_lrc + n_prc, 2);
    rdchk(`TSCR_IDX_CTRL, 16'h0000);
    host.wr(`TSCR_IDX_CTRL, 16'h0002);
    chk(current_power_mode_o, 3'h1);
    host.wr(`TSCR_IDX_CFG, 16'h0080);
    cyc(2);
    chk(manual_mode_o, 1'b1);
    chk(current_power_mode_o, 3'h2);
    for (m = 0; m < 5; m = m + 1) begin
      host.wr(`TSCR_IDX_CTRL, m[15:0]);
      chk(current_power_mode_o, m);
      rdchk(`TSCR_IDX_INFO, 16'h1148 | m);
    end
    host.wr(`TSCR_IDX_CFG, 16'h0000);
    win(1'b0, 5'h00, 1'b1);
    win(1'b1, 5'h00, 1'b0);
    host.wr(`TSCR_IDX_CFG, 16'h4100);
    win(1'b0, 5'h10, 1'b1);
    win(1'b0, 5'h01, 1'b0);
    host.wr(`TSCR_IDX_CFG, 16'h0900);
    rdchk(`TSCR_IDX_CFG, 16'h0900);
    win(1'b0, 5'h04, 1'b1);
    host.wr(`TSCR_IDX_CTRL, 16'h0200);
    cyc(4);
    chk(n_srst, 1);
    rdchk(`TSCR_IDX_INFO, 16'h11C9);
    summarize;
  end
  // the whole sequence needs about 18k clocks
  initial begin
    repeat (90000) @(posedge clk_i);
    fails = fails + 1;
    summarize;
  end
endmodule // testbench
